// ---- src/tebf_params.svh ----
// constants of the trigger and event bundle framer
`ifndef TEBF_PARAMS_SVH
`define TEBF_PARAMS_SVH
`define TEBF_TYPE_THR_EARLY   8'h14
`define TEBF_TYPE_THR_LATE    8'h15
`define TEBF_TYPE_STA_EARLY   8'h16
`define TEBF_TYPE_STA_LATE    8'h17
`define TEBF_TYPE_EVENT       8'h18
`define TEBF_TYPE_FILLER      8'h09
`define TEBF_CAUSE_EXTERNAL   8'h01
`define TEBF_CAUSE_INTERNAL   8'h02
`define TEBF_CAUSE_MANUAL     8'h04
`define TEBF_BUNDLE_LEN       5'd17
`define TEBF_LAST_IDX         5'd16
`define TEBF_SUBSEC_MAX       16'd9999
`define TEBF_FILL_BYTE        8'h00
`define TEBF_CHAN_POS         5
`define TEBF_TRIG_POS         0
`endif

// ---- src/tebf_pkg.sv ----
// types of the trigger and event bundle framer
package tebf_pkg;
    typedef struct packed {
        logic [31:0] seconds;
        logic [15:0] subsec;
        logic [31:0] long_term_average;
        logic [15:0] half_period;
        logic [15:0] peak_offset;
        logic [2:0]  channel;
        logic [4:0]  trigger;
        logic [23:0] peak_amp;
    } tebf_trig_t;

    typedef struct packed {
        logic [31:0] start_seconds;
        logic [31:0] end_seconds;
        logic [7:0]  cause;
        logic [7:0]  trig_flags;
    } tebf_event_t;

    typedef enum logic [2:0] {
        TEBF_K_THR_EARLY = 3'b000,
        TEBF_K_THR_LATE  = 3'b001,
        TEBF_K_STA_EARLY = 3'b010,
        TEBF_K_STA_LATE  = 3'b011,
        TEBF_K_EVENT     = 3'b100,
        TEBF_K_FILLER    = 3'b101
    } tebf_kind_t;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } tebf_byte_t;
endpackage : tebf_pkg

// ---- src/tebf_delay.sv ----
// programmable delay from a trigger edge to its report request
`timescale 1ns/100ps
module tebf_delay #(
    parameter int CNT_W = 24
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] delay,
    input  wire logic             taken,
    output logic                  due
);
    logic [CNT_W-1:0] cnt_reg,  cnt_next;
    logic             run_reg,  run_next;
    logic             due_reg,  due_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        due_next = due_reg;
        if (taken) begin
            due_next = 1'b0;
        end
        if (start) begin
            cnt_next = delay;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (cnt_reg == '0) begin
                run_next = 1'b0;
                due_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            due_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            due_reg <= due_next;
        end
    end

    assign due = due_reg;
endmodule : tebf_delay

// ---- src/tebf_serial.sv ----
// seventeen-byte bundle shift-out with ready/valid
`timescale 1ns/100ps
`include "tebf_params.svh"
module tebf_serial (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   load,
    input  wire logic [17*8-1:0]        bundle,
    output logic                        busy,
    output tebf_pkg::tebf_byte_t        out_byte,
    output logic                        out_valid,
    input  wire logic                   out_ready
);
    import tebf_pkg::*;
    logic [17*8-1:0] buf_reg, buf_next;
    logic [4:0]      idx_reg, idx_next;
    logic            vld_reg, vld_next;
    logic            first_reg, first_next;
    logic            last_reg, last_next;

    // the vector shifts up on every accepted byte, so the output byte is a plain flop slice
    always_comb begin
        buf_next   = buf_reg;
        idx_next   = idx_reg;
        vld_next   = vld_reg;
        first_next = first_reg;
        last_next  = last_reg;
        if (vld_reg && out_ready) begin
            buf_next   = {buf_reg[127:0], 8'h00};
            first_next = 1'b0;
            if (idx_reg == `TEBF_LAST_IDX) begin
                vld_next  = 1'b0;
                idx_next  = '0;
                last_next = 1'b0;
            end else begin
                idx_next  = idx_reg + 5'd1;
                last_next = (idx_reg == `TEBF_LAST_IDX - 5'd1);
            end
        end
        if (load && !vld_reg) begin
            buf_next   = bundle;
            idx_next   = '0;
            vld_next   = 1'b1;
            first_next = 1'b1;
            last_next  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_reg <= '0;
            idx_reg <= '0;
            vld_reg <= 1'b0;
            first_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            idx_reg <= idx_next;
            vld_reg <= vld_next;
            first_reg <= first_next;
            last_reg <= last_next;
        end
    end

    // byte 0 sits at the top of the vector
    assign out_byte.data  = buf_reg[135:128];
    assign out_byte.first = first_reg;
    assign out_byte.last  = last_reg;
    assign out_valid      = vld_reg;
    assign busy           = vld_reg;
endmodule : tebf_serial

// ---- src/tebf_framer.sv ----
// trigger report and event bundle framer
`timescale 1ns/100ps
`include "tebf_params.svh"
module tebf_framer #(
    parameter int CNT_W      = 24,
    parameter bit BIG_ENDIAN = 1'b1
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   thr_start,
    input  wire logic                   thr_end,
    input  wire logic                   sta_start,
    input  wire logic                   sta_end,
    input  wire tebf_pkg::tebf_trig_t   trig_stats,
    input  wire logic [CNT_W-1:0]       early_delay,
    input  wire logic [CNT_W-1:0]       late_delay,
    input  wire logic                   event_req,
    input  wire tebf_pkg::tebf_event_t  event_info,
    input  wire logic                   fill_req,
    output tebf_pkg::tebf_byte_t        out_byte,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic                        event_busy
);
    import tebf_pkg::*;

    // per report kind: 0 thr early, 1 thr late, 2 sta early, 3 sta late
    logic [3:0]  start_ev;
    logic [3:0]  due;
    logic [3:0]  take;
    tebf_trig_t  snap_reg [4];
    tebf_trig_t  snap_next [4];
    logic [1:0]  early_sent_reg, early_sent_next;
    logic        ev_pend_reg,    ev_pend_next;
    tebf_event_t ev_reg,         ev_next;
    logic        fill_pend_reg,  fill_pend_next;
    logic        ser_busy;
    logic        load;
    logic [135:0] bundle;
    logic        evb_reg;

    assign start_ev = {sta_end, sta_start, thr_end, thr_start};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dly
            tebf_delay #(.CNT_W(CNT_W)) u_dly (
                .clk   (clk),
                .nrst  (nrst),
                .start (start_ev[g]),
                .delay (g[0] ? late_delay : early_delay),
                .taken (take[g]),
                .due   (due[g])
            );
        end
    endgenerate

    // multi-byte field in the chosen byte order
    function automatic logic [31:0] ord(input logic [31:0] v, input int n);
        logic [31:0] r;
        r = v;
        if (!BIG_ENDIAN) begin
            r = '0;
            for (int i = 0; i < 4; i++) begin
                if (i < n) begin
                    r[(n-1-i)*8 +: 8] = v[i*8 +: 8];
                end
            end
        end
        return r;
    endfunction : ord

    function automatic logic [135:0] pack_report(input tebf_trig_t s, input logic [7:0] typ, input logic late);
        logic [31:0] sec;
        logic [31:0] sub;
        logic [31:0] avg;
        logic [31:0] hp;
        logic [31:0] po;
        logic [31:0] pk;
        logic [7:0]  ct;
        sec = ord(s.seconds, 4);
        sub = ord({16'h0000, s.subsec}, 2);
        avg = ord({16'h0000, late ? s.long_term_average[31:16] : s.long_term_average[15:0]}, 2);
        hp  = ord({16'h0000, s.half_period}, 2);
        po  = ord({16'h0000, s.peak_offset}, 2);
        pk  = ord({8'h00, s.peak_amp}, 3);
        ct  = {s.channel, s.trigger};
        return {typ, sec, sub[15:0], avg[15:0], hp[15:0], po[15:0], ct, pk[23:0]};
    endfunction : pack_report

    // pick the next bundle: early reports (thr, then sta), then late reports (thr, then sta), then event, then filler
    always_comb begin
        take   = 4'h0;
        load   = 1'b0;
        bundle = '0;
        if (!ser_busy) begin
            if (due[0]) begin
                take[0] = 1'b1;
                bundle  = pack_report(snap_reg[0], `TEBF_TYPE_THR_EARLY, 1'b0);
            end else if (due[2]) begin
                take[2] = 1'b1;
                bundle  = pack_report(snap_reg[2], `TEBF_TYPE_STA_EARLY, 1'b0);
            end else if (due[1] && early_sent_reg[0]) begin
                take[1] = 1'b1;
                bundle  = pack_report(snap_reg[1], `TEBF_TYPE_THR_LATE, 1'b1);
            end else if (due[3] && early_sent_reg[1]) begin
                take[3] = 1'b1;
                bundle  = pack_report(snap_reg[3], `TEBF_TYPE_STA_LATE, 1'b1);
            end else if (ev_pend_reg) begin
                bundle  = {`TEBF_TYPE_EVENT, ord(ev_reg.start_seconds, 4), ord(ev_reg.end_seconds, 4),
                           ev_reg.cause, ev_reg.trig_flags, 48'h0};
            end else if (fill_pend_reg) begin
                bundle  = {`TEBF_TYPE_FILLER, {16{`TEBF_FILL_BYTE}}};
            end
            load = |take || ev_pend_reg || fill_pend_reg;
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            snap_next[k] = snap_reg[k];
        end
        early_sent_next = early_sent_reg;
        ev_pend_next    = ev_pend_reg;
        ev_next         = ev_reg;
        fill_pend_next  = fill_pend_reg;
        // early stats are caught at the start edge and again each cycle their due report waits, late ones at the end edge that starts their delay
        for (int k = 0; k < 4; k++) begin
            if (start_ev[k]) begin
                snap_next[k] = trig_stats;
            end
            if (due[k] && !take[k] && k[0] == 1'b0) begin
                snap_next[k] = trig_stats;
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (take[2*c]) begin
                early_sent_next[c] = 1'b1;
            end
            if (take[2*c+1]) begin
                early_sent_next[c] = 1'b0;
            end
            if (start_ev[2*c]) begin
                early_sent_next[c] = 1'b0;
            end
        end
        if (load && !(|take) && ev_pend_reg) begin
            ev_pend_next = 1'b0;
        end else if (load && !(|take) && fill_pend_reg) begin
            fill_pend_next = 1'b0;
        end
        if (event_req && !ev_pend_reg) begin
            ev_pend_next = 1'b1;
            ev_next      = event_info;
        end
        if (fill_req) begin
            fill_pend_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < 4; k++) begin
                snap_reg[k] <= '0;
            end
            early_sent_reg <= '0;
            ev_pend_reg    <= 1'b0;
            ev_reg         <= '0;
            fill_pend_reg  <= 1'b0;
            evb_reg        <= 1'b0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                snap_reg[k] <= snap_next[k];
            end
            early_sent_reg <= early_sent_next;
            ev_pend_reg    <= ev_pend_next;
            ev_reg         <= ev_next;
            fill_pend_reg  <= fill_pend_next;
            evb_reg        <= ev_pend_next;
        end
    end

    tebf_serial u_ser (
        .clk       (clk),
        .nrst      (nrst),
        .load      (load),
        .bundle    (bundle),
        .busy      (ser_busy),
        .out_byte  (out_byte),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    assign event_busy = evb_reg;
endmodule : tebf_framer

// ---- tb/tebf_framer_chk.sv ----
// port assertions of the bundle framer
`timescale 1ns/100ps
`include "tebf_params.svh"
module tebf_framer_chk #(
    parameter int CNT_W = 24
) (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic                 thr_start,
    input wire logic [CNT_W-1:0]     early_delay,
    input wire logic                 event_req,
    input wire tebf_pkg::tebf_byte_t out_byte,
    input wire logic                 out_valid,
    input wire logic                 out_ready,
    input wire logic                 event_busy
);
    import tebf_pkg::*;
    logic [4:0] idx_reg, idx_next;
    logic [7:0] kind_reg, kind_next;
    logic [7:0] thr_reg, thr_next;
    logic [7:0] sta_reg, sta_next;
    wire        xfer = out_valid && out_ready;
    wire        head = out_valid && out_byte.first;
    // open early reports per trigger type, so a late one can be judged
    always_comb begin
        idx_next = idx_reg;
        kind_next = kind_reg;
        thr_next = thr_reg;
        sta_next = sta_reg;
        if (xfer) begin
            idx_next = out_byte.last ? 5'd0 : idx_reg + 5'd1;
            if (out_byte.first) kind_next = out_byte.data;
            if (head && out_byte.data == `TEBF_TYPE_THR_EARLY) thr_next = thr_reg + 8'h01;
            if (head && out_byte.data == `TEBF_TYPE_THR_LATE) thr_next = thr_reg - 8'h01;
            if (head && out_byte.data == `TEBF_TYPE_STA_EARLY) sta_next = sta_reg + 8'h01;
            if (head && out_byte.data == `TEBF_TYPE_STA_LATE) sta_next = sta_reg - 8'h01;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_reg <= 5'd0;
            kind_reg <= 8'h00;
            thr_reg <= 8'h00;
            sta_reg <= 8'h00;
        end else begin
            idx_reg <= idx_next;
            kind_reg <= kind_next;
            thr_reg <= thr_next;
            sta_reg <= sta_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_held;
        out_valid && $stable(out_byte);
    endsequence
    sequence s_thr_early;
        head && out_byte.data == `TEBF_TYPE_THR_EARLY;
    endsequence
    property p_hold;
        out_valid && !out_ready |=> s_held;
    endproperty
    property p_first;
        out_valid |-> out_byte.first == (idx_reg == 5'd0);
    endproperty
    property p_last;
        out_valid |-> out_byte.last == (idx_reg == `TEBF_LAST_IDX);
    endproperty
    property p_type;
        head |-> out_byte.data inside {[8'h14:8'h18], `TEBF_TYPE_FILLER};
    endproperty
    property p_fill;
        out_valid && !out_byte.first && kind_reg == `TEBF_TYPE_FILLER |-> out_byte.data == `TEBF_FILL_BYTE;
    endproperty
    property p_spare;
        out_valid && kind_reg == `TEBF_TYPE_EVENT && idx_reg > 5'd10 |-> out_byte.data == 8'h00;
    endproperty
    property p_thr_order;
        head && out_byte.data == `TEBF_TYPE_THR_LATE |-> thr_reg != 8'h00;
    endproperty
    property p_sta_order;
        head && out_byte.data == `TEBF_TYPE_STA_LATE |-> sta_reg != 8'h00;
    endproperty
    property p_evt_busy;
        event_req && !event_busy |=> event_busy;
    endproperty
    property p_early_due;
        thr_start && !out_valid && !event_busy && early_delay < 6 |-> ##[3:8] s_thr_early;
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed before accept");
    a_first: assert property (p_first) else $error("first flag misplaced");
    a_last: assert property (p_last) else $error("last flag misplaced");
    a_type: assert property (p_type) else $error("unknown bundle type");
    a_fill: assert property (p_fill) else $error("filler byte not zero");
    a_spare: assert property (p_spare) else $error("spare byte not zero");
    a_thr_order: assert property (p_thr_order) else $error("late threshold report first");
    a_sta_order: assert property (p_sta_order) else $error("late average report first");
    a_evt_busy: assert property (p_evt_busy) else $error("event not held pending");
    a_early_due: assert property (p_early_due) else $error("early report late");
endmodule : tebf_framer_chk

bind tebf_framer tebf_framer_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .nrst(nrst), .thr_start(thr_start),
    .early_delay(early_delay), .event_req(event_req), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready), .event_busy(event_busy));

// ---- tb/tebf_sink.sv ----
// packet assembler model: gathers bundles, stalls at random
`timescale 1ns/100ps
module tebf_sink (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 stall_en,
    input  wire tebf_pkg::tebf_byte_t out_byte,
    input  wire logic                 out_valid,
    output logic                      out_ready,
    output logic [135:0]              got_bundle,
    output logic                      got_stb,
    output logic                      pkt_end
);
    logic [135:0] acc;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_ready <= 1'b0;
            got_stb <= 1'b0;
            pkt_end <= 1'b0;
            acc = '0;
        end else begin
            got_stb <= 1'b0;
            out_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
            if (out_valid && out_ready) begin
                acc = {acc[127:0], out_byte.data};
                if (out_byte.last) begin
                    got_bundle <= acc;
                    got_stb <= 1'b1;
                    // a filler marks the end of useful data in the packet
                    pkt_end <= (acc[135:128] == 8'h09);
                end
            end
        end
    end
endmodule : tebf_sink

// ---- tb/trigger_event_bundle_framer_tb_top.sv ----
// self-checking bench of the trigger and event bundle framer
`timescale 1ns/100ps
module trigger_event_bundle_framer_tb_top;
    import tebf_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        thr_start = 1'b0, thr_end = 1'b0, sta_start = 1'b0, sta_end = 1'b0;
    logic        event_req = 1'b0, fill_req = 1'b0, stall_en = 1'b1;
    logic [23:0] early_delay = '0, late_delay = '0;
    tebf_trig_t  trig_stats = '0;
    tebf_event_t event_info = '0;
    tebf_byte_t  out_byte;
    logic        out_valid, out_ready, event_busy, got_stb;
    logic [135:0] got_bundle, exp_b;
    logic [135:0] exp_q[$];
    int          failures = 0;
    int          samples_checked = 0;
    always #12.5 clk = ~clk;
    tebf_framer i_dut (.clk(clk), .nrst(nrst), .thr_start(thr_start), .thr_end(thr_end), .sta_start(sta_start),
        .sta_end(sta_end), .trig_stats(trig_stats), .early_delay(early_delay), .late_delay(late_delay),
        .event_req(event_req), .event_info(event_info), .fill_req(fill_req), .out_byte(out_byte),
        .out_valid(out_valid), .out_ready(out_ready), .event_busy(event_busy));
    tebf_sink i_sink (.clk(clk), .nrst(nrst), .stall_en(stall_en), .out_byte(out_byte), .out_valid(out_valid),
        .out_ready(out_ready), .got_bundle(got_bundle), .got_stb(got_stb), .pkt_end());
    function automatic logic [135:0] report(input logic [7:0] code, input tebf_trig_t s, input logic late);
        report = {code, s.seconds, s.subsec, late ? s.long_term_average[31:16] : s.long_term_average[15:0],
                  s.half_period, s.peak_offset, s.channel, s.trigger, s.peak_amp};
    endfunction : report
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic rand_stats;
        logic [159:0] r;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        trig_stats = r[143:0];
        trig_stats.subsec = 16'($urandom_range(9999));
    endtask : rand_stats
    task automatic drain;
        int n;
        for (n = 0; n < 3000 && (exp_q.size() != 0 || out_valid); n++) tick(1);
        samples_checked++;
        if (exp_q.size() != 0) begin
            $display("MISMATCH pending_bundles expected 0 seen %0d", exp_q.size());
            failures++;
        end
    endtask : drain
    // back to back: the late report is due long before its early one
    task automatic trig_case(input logic short_term_average, input logic b2b);
        rand_stats();
        early_delay = b2b ? 24'd5 : 24'($urandom_range(5));
        late_delay = b2b ? 24'd0 : 24'($urandom_range(5));
        thr_start = !short_term_average;
        sta_start = short_term_average;
        exp_q.push_back(report(short_term_average ? 8'h16 : 8'h14, trig_stats, 1'b0));
        tick(1);
        thr_start = 1'b0;
        sta_start = 1'b0;
        if (!b2b) tick(12);
        if (!b2b) rand_stats();
        thr_end = !short_term_average;
        sta_end = short_term_average;
        exp_q.push_back(report(short_term_average ? 8'h17 : 8'h15, trig_stats, 1'b1));
        tick(1);
        thr_end = 1'b0;
        sta_end = 1'b0;
        if (!b2b) rand_stats();
        drain();
    endtask : trig_case
    // the event waits behind a filler, so a second request finds it pending
    task automatic event_case(input logic [7:0] cause);
        fill_req = 1'b1;
        exp_q.push_back({8'h09, 128'h0});
        tick(1);
        fill_req = 1'b0;
        tick(3);
        event_info = {$urandom, $urandom, cause, 8'($urandom)};
        exp_q.push_back({8'h18, event_info, 48'h0});
        event_req = 1'b1;
        tick(1);
        event_req = 1'b0;
        tick(2);
        event_info = ~event_info;
        event_req = 1'b1;
        tick(1);
        event_req = 1'b0;
        drain();
    endtask : event_case
    always @(posedge clk) begin
        if (got_stb === 1'b1) begin
            samples_checked++;
            if (exp_q.size() == 0) begin
                $display("MISMATCH bundle expected none seen %h", got_bundle);
                failures++;
            end else begin
                exp_b = exp_q.pop_front();
                if (got_bundle !== exp_b) begin
                    $display("MISMATCH bundle expected %h seen %h", exp_b, got_bundle);
                    failures++;
                end
            end
        end
    end
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        void'($urandom(32'h178ff3df));
        tick(2);
        nrst = 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) trig_case(i[0], i[1]);
        event_case(8'h01);
        event_case(8'h02);
        event_case(8'h04);
        stall_en = 1'b0;
        trig_case(1'b0, 1'b1);
        print_verdict();
    end
    // the whole sequence needs well under 2000 cycles even with stalls
    initial begin
        #(25 * 20000);
        failures++;
        print_verdict();
    end
endmodule : trigger_event_bundle_framer_tb_top
